// file: logic/aote_engine.sv
/*
  Analog output timing engine: update clock divider, begin trigger,
  hold trigger, sample FIFO and software-timed conversion path.
  Assumes host data, commands and module masks come from logic on clk;
  external pins arrive asynchronously and are synchronised here.
*/
// Operation
// - every channel of the hardware task updates together per update pulse
// - update clock is a divided internal or external timebase
// - timebase is never offered on an output terminal
// - update clock routable to terminal, active high unless inverted
// - generation begins on trigger, or on software start without trigger
// - internal clock inserts programmable delay after the begin trigger
// - digital begin source selectable, rising or falling edge
// - analog comparison source begins on its first configured edge
// - hardware generation always passes through the onboard FIFO
// - finite mode stops after the preset sample count
// - continuous mode runs until a stop command
// - regeneration accepts new host data at any time
// - onboard regeneration loads once, replays, then refuses host data
// - onboard regeneration limited to sixteen channels
// - non-regeneration never repeats samples; empty FIFO raises underflow
// - reject a module split between hardware and software tasks
// - either task kind may span several modules
// - one software conversion per host command, no pacing
// - one simultaneous software task, never beside a hardware task
// - optional filters on update clock, begin and hold, not timebase
// - two parallel digital input modules may supply the trigger
// - hold blocks new samples from the next sample boundary
// - external clock resumes on next edge; internal resumes at once (here the internal divider finishes its paused count)
// - begin trigger routable to terminal as active high pulse
`timescale 1ns/1ns
`include "aote_regs.svh"

module aote_engine #(
  parameter int DW    = 64,
  parameter int DEPTH = 16,
  parameter int CW    = 16,
  parameter int SCW   = 24,
  parameter int NM    = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ext_timebase,
  input  wire logic              ext_update_clk,
  input  wire logic              term_begin,
  input  wire logic              output_hold_trigger,
  input  wire logic              din0_trigger,
  input  wire logic              din1_trigger,
  input  wire logic              ai_ref_trigger,
  input  wire logic              ai_start_trigger,
  input  wire logic              acmp_event,
  input  wire logic              host_begin_pulse,
  input  wire logic              timebase_ext,
  input  wire logic              update_clk_ext,
  input  wire logic [CW-1:0]     divisor,
  input  wire logic [CW-1:0]     start_delay,
  input  wire logic [2:0]        begin_src,
  input  wire logic              begin_fall,
  input  wire logic              trig_none,
  input  wire logic              hold_en,
  input  wire logic              hold_level,
  input  wire logic [2:0]        filter_en,
  input  wire logic              finite_mode,
  input  wire logic [SCW-1:0]    sample_count,
  input  wire logic [1:0]        regen_mode,
  input  wire logic [5:0]        chan_count,
  input  wire logic [NM-1:0]     hw_mask,
  input  wire logic [NM-1:0]     sw_mask,
  input  wire logic [1:0]        term_route,
  input  wire logic              update_invert,
  input  wire logic              sw_start,
  input  wire logic              sw_stop,
  input  wire logic              sw_clear,
  input  wire logic              sw_open_req,
  input  wire logic              sw_close_req,
  input  wire logic              sw_convert,
  input  wire logic [DW-1:0]     sw_value,
  input  wire logic              host_valid,
  input  wire logic [DW-1:0]     host_data,
  output logic                   host_ready,
  output logic                   dac_update,
  output logic [DW-1:0]          dac_data,
  output logic [NM-1:0]          dac_modules,
  output logic                   sw_update,
  output logic [DW-1:0]          sw_data,
  output logic                   programmable_terminal,
  output logic                   underflow,
  output logic                   cfg_reject,
  output logic                   running,
  output logic                   finished
);

  localparam int AW = $clog2(DEPTH);
  localparam int NP = 6;
  localparam int FW = 4;
  localparam logic [FW-1:0] FILT_LAST = FW'(`AOTE_FILT_CYC - 1);
  localparam logic [AW:0]   FULL      = (AW + 1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || `AOTE_FILT_CYC > 16)
  begin : g_check
    $error("aote_engine: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    aote_pkg::aote_state_t     st;
    logic [NP-1:0][2:0]        sy;
    logic [NP-1:0]             stb;
    logic [NP-1:0][FW-1:0]     fc;
    logic [NP-1:0]             cln;
    logic                      tb_prev;
    logic                      uc_prev;
    logic                      tr_prev;
    logic [CW-1:0]             div;
    logic [CW-1:0]             dly;
    logic [SCW-1:0]            done_cnt;
    logic [DEPTH-1:0][DW-1:0]  mem;
    logic [AW-1:0]             wp;
    logic [AW-1:0]             rp;
    logic [AW:0]               cnt;
    logic                      loaded;
    logic                      sw_open;
    logic                      host_ready;
    logic                      dac_update;
    logic [DW-1:0]             dac_data;
    logic [NM-1:0]             dac_modules;
    logic                      sw_update;
    logic [DW-1:0]             sw_data;
    logic                      term;
    logic                      underflow;
    logic                      cfg_reject;
    logic                      running;
    logic                      finished;
  } aote_st_t;

  aote_st_t q;
  aote_st_t n;

  logic [NP-1:0] pins;
  logic [NP-1:0] fe;
  logic [7:0]    srcs;
  logic          onboard;
  logic          tb_tick;
  logic          int_tick;
  logic          uc_tick;
  logic          hold_act;
  logic          trig_sel;
  logic          trig_evt;
  logic          cfg_bad;
  logic          do_push;

  assign pins = {din1_trigger, din0_trigger, output_hold_trigger,
                 term_begin, ext_update_clk, ext_timebase};
  assign fe = {filter_en[1], filter_en[1], filter_en[2], filter_en[1],
               filter_en[0], 1'b0};
  assign onboard = regen_mode == `AOTE_MODE_ONBOARD;
  assign tb_tick = timebase_ext ? (q.cln[`AOTE_PIN_TB] & ~q.tb_prev) : 1'b1;
  assign int_tick = tb_tick && q.div == divisor - 1'b1;
  assign uc_tick = update_clk_ext ? (q.cln[`AOTE_PIN_UCLK] & ~q.uc_prev)
                                  : int_tick;
  assign hold_act = hold_en && q.cln[`AOTE_PIN_HOLD] == hold_level;
  assign srcs = {1'b0, q.cln[`AOTE_PIN_DIN1], q.cln[`AOTE_PIN_DIN0],
                 acmp_event, ai_start_trigger, ai_ref_trigger,
                 q.cln[`AOTE_PIN_TERM], host_begin_pulse};
  assign trig_sel = srcs[begin_src];
  assign trig_evt = begin_fall ? (~trig_sel & q.tr_prev)
                               : (trig_sel & ~q.tr_prev);
  assign cfg_bad = (|(hw_mask & sw_mask))
                || (onboard && chan_count > `AOTE_ONBOARD_MAX_CH)
                || q.sw_open;
  assign do_push = host_valid && q.host_ready;

  always_comb
  begin
    logic go;
    logic upd;
    logic pop;
    go  = 1'b0;
    upd = 1'b0;
    pop = 1'b0;
    n = q;
    n.sw_update = 1'b0;
    n.tb_prev = q.cln[`AOTE_PIN_TB];
    n.uc_prev = q.cln[`AOTE_PIN_UCLK];
    n.tr_prev = trig_sel;
    for (int i = 0; i < NP; i++)
    begin
      n.sy[i] = {q.sy[i][1:0], pins[i]};
      if (q.sy[i][1] == q.sy[i][2])
        n.stb[i] = q.sy[i][2];
      if (!fe[i] || q.stb[i] == q.cln[i])
      begin
        n.fc[i] = '0;
        n.cln[i] = q.stb[i];
      end
      else if (q.fc[i] == FILT_LAST)
      begin
        n.fc[i] = '0;
        n.cln[i] = q.stb[i];
      end
      else
        n.fc[i] = q.fc[i] + 1'b1;
    end
    if (sw_clear || sw_stop)
      n.underflow = 1'b0;
    unique case (q.st)
      aote_pkg::ST_IDLE, aote_pkg::ST_DONE:
      begin
        if (sw_start)
        begin
          n.cfg_reject = cfg_bad;
          if (!cfg_bad && trig_none)
            go = 1'b1;
          else if (!cfg_bad)
            n.st = aote_pkg::ST_ARM;
        end
      end
      aote_pkg::ST_ARM:
        if (trig_evt)
          go = 1'b1;
      aote_pkg::ST_DELAY:
      begin
        if (q.dly == start_delay - 1'b1)
          n.st = aote_pkg::ST_RUN;
        else
          n.dly = q.dly + 1'b1;
      end
      aote_pkg::ST_RUN:
      begin
        if (uc_tick && !hold_act)
        begin
          if (onboard && q.cnt != '0)
          begin
            upd = 1'b1;
            n.dac_data = q.mem[q.rp];
            n.rp = ({1'b0, q.rp} + 1'b1 == q.cnt) ? '0 : q.rp + 1'b1;
          end
          else if (!onboard && q.cnt != '0)
          begin
            upd = 1'b1;
            pop = 1'b1;
            n.dac_data = q.mem[q.rp];
            n.rp = q.rp + 1'b1;
          end
          // never repeat; flag the starved sample
          else if (regen_mode == `AOTE_MODE_NONREGEN)
            n.underflow = 1'b1;
        end
        if (upd)
          n.done_cnt = q.done_cnt + 1'b1;
        if (upd && finite_mode && q.done_cnt + 1'b1 == sample_count)
          n.st = aote_pkg::ST_DONE;
      end
      default:
        n.st = aote_pkg::ST_IDLE;
    endcase
    if (go)
    begin
      n.cfg_reject = 1'b0;
      n.done_cnt = '0;
      n.dly = '0;
      n.loaded = onboard;
      // delay only with the internal clock
      n.st = (!update_clk_ext && start_delay != '0) ? aote_pkg::ST_DELAY
                                                    : aote_pkg::ST_RUN;
    end
    if (q.st != aote_pkg::ST_RUN)
      n.div = '0;
    else if (tb_tick && !hold_act)
      n.div = int_tick ? '0 : q.div + 1'b1;
    if (do_push)
    begin
      n.mem[q.wp] = host_data;
      n.wp = q.wp + 1'b1;
    end
    if (do_push && !pop)
      n.cnt = q.cnt + 1'b1;
    else if (pop && !do_push)
      n.cnt = q.cnt - 1'b1;
    if (sw_open_req && (q.sw_open || q.running))
      n.cfg_reject = 1'b1;
    else if (sw_open_req)
      n.sw_open = 1'b1;
    if (sw_close_req)
      n.sw_open = 1'b0;
    if (sw_convert)
    begin
      n.sw_update = 1'b1;
      n.sw_data = sw_value;
    end
    if (sw_stop)
    begin
      n.st = aote_pkg::ST_IDLE;
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
      n.loaded = 1'b0;
      upd = 1'b0;
    end
    // one strobe for all hardware-task modules
    n.dac_update = upd;
    n.dac_modules = upd ? hw_mask : '0;
    n.host_ready = n.cnt != FULL && !n.loaded;
    n.running = n.st == aote_pkg::ST_ARM || n.st == aote_pkg::ST_DELAY
             || n.st == aote_pkg::ST_RUN;
    n.finished = n.st == aote_pkg::ST_DONE;
    unique case (term_route)
      `AOTE_ROUTE_UPDATE: n.term = upd ^ update_invert;
      `AOTE_ROUTE_BEGIN:  n.term = go;
      default:            n.term = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end

  assign host_ready            = q.host_ready;
  assign dac_update            = q.dac_update;
  assign dac_data              = q.dac_data;
  assign dac_modules           = q.dac_modules;
  assign sw_update             = q.sw_update;
  assign sw_data               = q.sw_data;
  assign programmable_terminal = q.term;
  assign underflow             = q.underflow;
  assign cfg_reject            = q.cfg_reject;
  assign running               = q.running;
  assign finished              = q.finished;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_finite;
    q.st == aote_pkg::ST_RUN && finite_mode && sample_count != '0
      |-> q.done_cnt < sample_count;
  endproperty
  a_finite: assert property (p_finite) else $error("finite overrun");

  property p_underflow;
    q.st == aote_pkg::ST_RUN && uc_tick && !hold_act && q.cnt == '0
      && regen_mode == `AOTE_MODE_NONREGEN |=> underflow && !dac_update;
  endproperty
  a_underflow: assert property (p_underflow) else $error("no underflow");

  property p_sticky;
    underflow && !sw_stop && !sw_clear |=> underflow;
  endproperty
  a_sticky: assert property (p_sticky) else $error("underflow lost");

  property p_loaded;
    q.loaded |-> !host_ready;
  endproperty
  a_loaded: assert property (p_loaded) else $error("host data after load");

  property p_split;
    !running && sw_start && (|(hw_mask & sw_mask)) |=> cfg_reject && !running;
  endproperty
  a_split: assert property (p_split) else $error("split module taken");

  property p_swstart;
    q.st == aote_pkg::ST_IDLE && sw_start && trig_none && !cfg_bad
      && !sw_stop |=> running ##1 !finished;
  endproperty
  a_swstart: assert property (p_swstart) else $error("no software start");

  property p_hold;
    q.st == aote_pkg::ST_RUN && hold_act |=> !dac_update;
  endproperty
  a_hold: assert property (p_hold) else $error("sample during hold");

  property p_convert;
    sw_convert |=> sw_update && sw_data == $past(sw_value);
  endproperty
  a_convert: assert property (p_convert) else $error("conversion lost");

  property p_fifo;
    q.st == aote_pkg::ST_RUN && q.cnt == '0 |=> !dac_update;
  endproperty
  a_fifo: assert property (p_fifo) else $error("update without FIFO");

  c_finish: cover property ($rose(finished));
  c_hold: cover property (q.st == aote_pkg::ST_RUN && hold_act ##1 !hold_act);
  c_under: cover property ($rose(underflow));
  c_onboard: cover property (dac_update && q.loaded);

endmodule : aote_engine

// file: logic/aote_regs.svh
/*
  Codes and timing counts of the analog output timing engine.
  Assumes the engine is clocked at the chassis timebase rate.
*/
`ifndef AOTE_REGS_SVH
`define AOTE_REGS_SVH

// Begin trigger source selection
`define AOTE_SRC_HOST     3'h0
`define AOTE_SRC_TERM     3'h1
`define AOTE_SRC_AI_REF   3'h2
`define AOTE_SRC_AI_START 3'h3
`define AOTE_SRC_ACMP     3'h4
`define AOTE_SRC_DIN0     3'h5
`define AOTE_SRC_DIN1     3'h6

// Continuous generation modes
`define AOTE_MODE_REGEN    2'h0
`define AOTE_MODE_ONBOARD  2'h1
`define AOTE_MODE_NONREGEN 2'h2

// Programmable terminal routes; the timebase has no route
`define AOTE_ROUTE_NONE   2'h0
`define AOTE_ROUTE_UPDATE 2'h1
`define AOTE_ROUTE_BEGIN  2'h2

`define AOTE_ONBOARD_MAX_CH 6'h10

// Pin slots of the synchroniser array
`define AOTE_PIN_TB    0
`define AOTE_PIN_UCLK  1
`define AOTE_PIN_TERM  2
`define AOTE_PIN_HOLD  3
`define AOTE_PIN_DIN0  4
`define AOTE_PIN_DIN1  5

`define AOTE_CLK_NS  40
`define AOTE_FILT_NS 200
`define AOTE_FILT_CYC ((`AOTE_FILT_NS + `AOTE_CLK_NS - 1) / `AOTE_CLK_NS)

`endif

// file: logic/aote_pkg.sv
/*
  Types of the analog output timing engine.
  Assumes nothing of its surroundings.
*/
package aote_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_ARM,
    ST_DELAY,
    ST_RUN,
    ST_DONE
  } aote_state_t;

endpackage : aote_pkg

// file: verification/aote_host_model.sv
/*
  Host buffer and output module side of the timing engine.
  Assumes the bench raises feed to stream words and holds rst high at start.
*/
`timescale 1ns/1ns
module aote_host_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        feed,
  input  wire logic        host_ready,
  input  wire logic        dac_update,
  input  wire logic        sw_update,
  output logic             host_valid,
  output logic [63:0]      host_data,
  output logic [63:0]      next_word,
  output int               upd_count,
  output int               sw_count
);
  logic took;
  logic want;
  always @(posedge clk)
  begin
    took <= host_valid && host_ready;
    want <= feed;
  end
  always @(negedge clk or posedge rst)
  begin
    if (rst)
    begin
      next_word  <= 64'h1;
      host_valid <= 1'b0;
    end
    else
    begin
      if (took)
        next_word <= next_word + 64'h1;
      host_valid <= want;
    end
  end
  // Released lines never keep the last word
  assign host_data = host_valid ? next_word : ~next_word;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      upd_count <= 0;
      sw_count  <= 0;
    end
    else
    begin
      upd_count <= upd_count + int'(dac_update);
      sw_count  <= sw_count + int'(sw_update);
    end
  end
endmodule : aote_host_model

// file: verification/analog_output_timing_engine_tb.sv
/*
  Self-checking bench of the analog output timing engine.
  Assumes the host model on the far side and a 25 MHz clock.
*/
`timescale 1ns/1ns
`include "aote_regs.svh"
module analog_output_timing_engine_tb;
  logic clk, rst, ext_timebase, ext_update_clk, term_begin, feed;
  logic output_hold_trigger, din0_trigger, din1_trigger, ai_ref_trigger;
  logic ai_start_trigger, acmp_event, host_begin_pulse, timebase_ext;
  logic update_clk_ext, begin_fall, trig_none, hold_en, hold_level;
  logic finite_mode, update_invert, sw_start, sw_stop, sw_clear;
  logic sw_open_req, sw_close_req, sw_convert, host_valid, host_ready;
  logic dac_update, sw_update, programmable_terminal, underflow;
  logic cfg_reject, running, finished;
  logic [15:0] divisor, start_delay;
  logic [2:0]  begin_src, filter_en;
  logic [23:0] sample_count;
  logic [1:0]  regen_mode, term_route;
  logic [5:0]  chan_count;
  logic [7:0]  hw_mask, sw_mask, dac_modules;
  logic [63:0] sw_value, host_data, dac_data, sw_data, next_word;
  int          failures, cmp_count, cycles, upd_count, sw_count;

  aote_engine dut_u (.*);
  aote_host_model hm_u (.clk(clk), .rst(rst), .feed(feed),
    .host_ready(host_ready), .dac_update(dac_update),
    .sw_update(sw_update), .host_valid(host_valid),
    .host_data(host_data), .next_word(next_word),
    .upd_count(upd_count), .sw_count(sw_count));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test;
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // Whole run needs well under this many cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic c, input string m);
    cmp_count++;
    if (c !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse

  // Bounded wait, sampled at the falling edge
  task automatic wait_hi(ref logic s, input int lim, output int n);
    for (n = 0; n < lim && s !== 1'b1; n++)
      cyc(1);
  endtask : wait_hi

  task automatic idle;
    feed = 1'b0;
    cyc(2);
    pulse(sw_stop);
    cyc(2);
  endtask : idle

  task automatic t_finite;
    logic [63:0] w0;
    int u0, n;
    w0 = next_word;
    feed = 1'b1;
    cyc(6);
    feed = 1'b0;
    finite_mode = 1'b1;
    sample_count = 24'h000004;
    u0 = upd_count;
    pulse(sw_start);
    chk(running === 1'b1, "no start");
    wait_hi(dac_update, 10, n);
    chk(dac_data === w0, "first word");
    chk(dac_modules === hw_mask, "modules");
    wait_hi(finished, 20, n);
    // Last pulse is counted by the model one edge later
    cyc(1);
    chk(finished === 1'b1 && upd_count - u0 == 4, "finite");
    finite_mode = 1'b0;
    idle();
  endtask : t_finite

  task automatic t_timing;
    int n, g;
    divisor = 16'h0005;
    start_delay = 16'h000A;
    feed = 1'b1;
    cyc(4);
    pulse(sw_start);
    wait_hi(dac_update, 40, n);
    chk(n >= 11 && n <= 17, "delay");
    cyc(1);
    wait_hi(dac_update, 20, g);
    chk(g == 4, "divide");
    divisor = 16'h0001;
    start_delay = 16'h0000;
    idle();
  endtask : t_timing

  task automatic t_begin;
    logic [2:0] src [4];
    logic [3:0] lv;
    int k, f, u0, n;
    src = '{`AOTE_SRC_HOST, `AOTE_SRC_AI_REF, `AOTE_SRC_AI_START,
            `AOTE_SRC_ACMP};
    trig_none = 1'b0;
    for (k = 0; k < 4; k++)
      for (f = 0; f < 2; f++)
      begin
        // Host pulse has no idle-high form
        if (k == 0 && f == 1)
          continue;
        lv = {4{f[0]}};
        {host_begin_pulse, ai_ref_trigger, ai_start_trigger, acmp_event} = lv;
        begin_src = src[k];
        begin_fall = f[0];
        feed = 1'b1;
        u0 = upd_count;
        pulse(sw_start);
        lv = lv ^ ~(4'h8 >> k);
        {host_begin_pulse, ai_ref_trigger, ai_start_trigger, acmp_event} = lv;
        cyc(8);
        chk(running === 1'b1 && upd_count == u0, "armed");
        lv = lv ^ (4'h8 >> k);
        {host_begin_pulse, ai_ref_trigger, ai_start_trigger, acmp_event} = lv;
        wait_hi(dac_update, 20, n);
        chk(dac_update === 1'b1, "no begin");
        cyc(4);
        chk(host_ready === 1'b1, "regen");
        idle();
      end
    trig_none = 1'b1;
  endtask : t_begin

  task automatic t_underflow;
    int u0;
    regen_mode = `AOTE_MODE_NONREGEN;
    u0 = upd_count;
    pulse(sw_start);
    cyc(30);
    chk(underflow === 1'b1 && running === 1'b1, "underflow");
    chk(upd_count == u0, "repeat");
    // A starved sample in the stop cycle sets the flag again; set wins
    pulse(sw_stop);
    pulse(sw_clear);
    chk(underflow === 1'b0 && running === 1'b0, "clear");
    regen_mode = `AOTE_MODE_REGEN;
  endtask : t_underflow

  task automatic t_sw;
    int s0;
    pulse(sw_open_req);
    pulse(sw_start);
    cyc(1);
    chk(cfg_reject === 1'b1 && running === 1'b0, "sw beside hw");
    s0 = sw_count;
    sw_value = 64'h0123456789ABCDEF;
    sw_convert = 1'b1;
    cyc(2);
    sw_convert = 1'b0;
    cyc(3);
    chk(sw_count - s0 == 2 && sw_data === sw_value, "convert");
    pulse(sw_close_req);
    cyc(1);
  endtask : t_sw

  // Clears a standing reject so the next refusal is visible
  task automatic t_good;
    pulse(sw_start);
    cyc(1);
    chk(cfg_reject === 1'b0 && running === 1'b1, "good start");
    pulse(sw_stop);
  endtask : t_good

  task automatic t_hold;
    int n;
    term_route = `AOTE_ROUTE_UPDATE;
    hold_en = 1'b1;
    hold_level = 1'b1;
    feed = 1'b1;
    cyc(4);
    pulse(sw_start);
    wait_hi(dac_update, 10, n);
    chk(programmable_terminal === 1'b1, "update on terminal");
    output_hold_trigger = 1'b1;
    cyc(6);
    wait_hi(dac_update, 6, n);
    chk(n == 6, "sample during hold");
    output_hold_trigger = 1'b0;
    wait_hi(dac_update, 12, n);
    chk(dac_update === 1'b1, "no resume");
    idle();
    term_route = `AOTE_ROUTE_BEGIN;
    pulse(sw_start);
    chk(programmable_terminal === 1'b1, "begin on terminal");
    cyc(1);
    chk(programmable_terminal === 1'b0, "begin pulse width");
    term_route = `AOTE_ROUTE_NONE;
    hold_en = 1'b0;
    idle();
  endtask : t_hold

  task automatic t_reject;
    int u0;
    t_good();
    sw_mask = 8'h06;
    pulse(sw_start);
    cyc(1);
    chk(cfg_reject === 1'b1 && running === 1'b0, "split");
    sw_mask = 8'h0C;
    t_good();
    regen_mode = `AOTE_MODE_ONBOARD;
    chan_count = 6'h11;
    feed = 1'b1;
    cyc(4);
    feed = 1'b0;
    pulse(sw_start);
    cyc(1);
    chk(cfg_reject === 1'b1 && running === 1'b0, "17 ch");
    chan_count = `AOTE_ONBOARD_MAX_CH;
    u0 = upd_count;
    pulse(sw_start);
    feed = 1'b1;
    cyc(20);
    chk(host_ready === 1'b0 && upd_count - u0 > 10, "onboard");
    pulse(sw_open_req);
    cyc(1);
    chk(cfg_reject === 1'b1, "sw open");
    idle();
  endtask : t_reject

  initial
  begin
    {ext_timebase, ext_update_clk, term_begin, output_hold_trigger,
     din0_trigger, din1_trigger, ai_ref_trigger, ai_start_trigger,
     acmp_event, host_begin_pulse, timebase_ext, update_clk_ext,
     begin_fall, hold_en, hold_level, finite_mode, update_invert,
     sw_start, sw_stop, sw_clear, sw_open_req, sw_close_req,
     sw_convert, feed} = '0;
    {filter_en, sample_count, term_route, start_delay} = '0;
    trig_none = 1'b1;
    divisor = 16'h0001;
    begin_src = `AOTE_SRC_HOST;
    regen_mode = `AOTE_MODE_REGEN;
    chan_count = 6'h04;
    hw_mask = 8'h03;
    sw_mask = 8'h0C;
    sw_value = 64'h0;
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    rst = 1'b1;
    cyc(3);
    chk(host_ready === 1'b0 && running === 1'b0, "in reset");
    rst = 1'b0;
    cyc(2);
    chk(host_ready === 1'b1 && dac_update === 1'b0, "after reset");
    t_finite();
    t_timing();
    t_begin();
    t_underflow();
    t_sw();
    t_hold();
    t_reject();
    end_of_test();
  end
endmodule : analog_output_timing_engine_tb
